//--- src/rsf_pkg.sv
package rsf_pkg;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] A_PHASE = 8'h00;
  localparam logic [7:0] A_CHAIN = 8'h04;
  localparam logic [7:0] A_FGROUP = 8'h08;
  localparam logic [7:0] A_USER = 8'h0C;
  localparam logic [7:0] A_OTLIM = 8'h10;
  localparam logic [7:0] A_UTLIM = 8'h14;
  localparam logic [7:0] A_NVCMD = 8'h18;
  localparam logic [7:0] A_STATE = 8'h1C;
  localparam logic [7:0] A_ISTAT = 8'h20;
  localparam logic [7:0] A_IEN = 8'h24;
  localparam logic [7:0] A_ICLR = 8'h28;
  localparam logic [2:0] A_MON_HI = 3'h2;  // 0x40..0x5C, eight readings
  localparam logic [3:0] A_SNAP_HI = 4'h6; // 0x60..0x6C, four snapshot words

  // ****************************************
  // Field layout
  // ****************************************
  localparam int PH_W = 4;    // Sixteen steps of 22.5 degrees
  localparam int ID_W = 6;
  localparam int CH_PREV = 8;
  localparam int CH_NEXT = 16;
  localparam int FG_BC = 0;
  localparam int FG_FOL = 1;
  localparam int FG_GRP = 8;
  localparam int U_EXT = 0;
  localparam int U_SHUT = 1;
  localparam int NV_STORE = 0;
  localparam int NV_RESTORE = 1;
  localparam int NV_LVL = 2;
  localparam logic [1:0] LVL_USER = 2'h0;
  localparam logic [1:0] LVL_FACTORY = 2'h1;
  localparam logic [ID_W-1:0] ID_NONE = 6'h00;

  // ****************************************
  // Inter-module bus message types
  // ****************************************
  localparam logic [1:0] MSG_UP = 2'h1;
  localparam logic [1:0] MSG_DOWN = 2'h2;
  localparam logic [1:0] MSG_FAULT = 2'h3;

  // ****************************************
  // Interrupt status bits
  // ****************************************
  localparam int IRQ_W = 5;
  localparam int I_FAULT = 0;
  localparam int I_GRP = 1;
  localparam int I_SEQ = 2;
  localparam int I_STORE = 3;
  localparam int I_REFUSE = 4;

  // ****************************************
  // Factory settings: {ut, ot, shut, ext, grp, fol, bc, next, prev, own, phase}
  // ****************************************
  localparam int CFG_W = 64;
  localparam logic [CFG_W-1:0] DEF_CFG = 64'hFFD3_007D_8000_0000;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ = 40;
  localparam int BIT_NS = 4000;
  localparam int BIT_CYC = (BIT_NS * CLK_MHZ + 999) / 1000;
  localparam int RETRY_US = 100;
  localparam int RETRY_CYC = RETRY_US * CLK_MHZ;

  // ****************************************
  // Sequencer states
  // ****************************************
  typedef enum logic [5:0] {
    S_OFF = 6'h01,
    S_WAIT_PREV = 6'h02,
    S_RAMP = 6'h04,
    S_ON = 6'h08,
    S_WAIT_NEXT = 6'h10,
    S_FAULT = 6'h20
  } rsf_state_t;

endpackage

//--- src/rsf_sync.sv
`timescale 1ns/1ps
`default_nettype none

// Two-flop synchroniser for pins from outside the clock domain
module rsf_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;

  // First stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule // rsf_sync

`default_nettype wire

//--- src/rsf_top.sv
// Function
// - Delay switching cycle start after sync edge by phase times 22.5 degrees.
// - Host writes predecessor and successor ids; device holds both links.
// - Common enable low makes the group turn off in order.
// - Fault broadcast enable and group id are software settable.
// - Own fault with shutdown response turns rail off and broadcasts.
// - Following devices shut down on a matching group fault message.
// - After group fault shutdown, restart follows the chain order.
// - User option selects external diode temperature for fault checks.
// - Host can read eight monitored quantities.
// - On a fault that shuts the rail, latch measurements and fault flags for later reading.
// - At start-up apply stored settings in place of factory defaults.
// - Store command writes current settings into nonvolatile memory.
// - Restore allowed only from user and factory levels; protected levels refused.
// - Device starts with factory defaults that software may overwrite.
// - One shared wire carries ordering and fault messages between devices.
`timescale 1ns/1ps
`default_nettype none

module rsf_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Group pins
  input wire logic grp_enable,
  input wire logic sync_clk,
  input wire logic imb_in,
  output logic imb_out,
  output logic imb_oe_n,
  // Power stage
  input wire logic pg_in,
  input wire logic nd_fault,
  output logic rail_en,
  output logic cycle_start,
  // Monitored readings
  input wire logic [15:0] mon_vin,
  input wire logic [15:0] mon_vout,
  input wire logic [15:0] mon_iout,
  input wire logic [15:0] mon_temp_int,
  input wire logic [15:0] mon_temp_ext,
  input wire logic [15:0] mon_duty,
  input wire logic [15:0] mon_freq,
  input wire logic [15:0] mon_aux,
  // Nonvolatile memory
  input wire logic nvm_valid,
  input wire logic [63:0] nvm_rd_data,
  output logic nvm_wr,
  output logic [63:0] nvm_wr_data,
  // Interrupt
  output logic irq
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic en_s, sync_s, imb_s, pg_s, sync_d, imb_d;

  rsf_sync #(.W(4)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({grp_enable, sync_clk, imb_in, pg_in}),
    .q({en_s, sync_s, imb_s, pg_s})
  );

  // ****************************************
  // Settings and APB decode
  // ****************************************
  logic [3:0] phase;
  logic [5:0] own_id, prev_id, next_id, grp_id;
  logic bcast, follow, ext_sel, shut_resp, init_pend;
  logic [15:0] ot_lim, ut_lim;
  localparam int IRQ_W_L = rsf_pkg::IRQ_W;
  logic [IRQ_W_L-1:0] istat, ien;
  wire [63:0] cfg = {ut_lim, ot_lim, shut_resp, ext_sel, grp_id, follow, bcast,
                     next_id, prev_id, own_id, phase};

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    return a == b;
  endfunction

  wire acc_wait = psel && penable && !pready;
  wire wr = psel && penable && pready && pwrite;
  wire wr_nv = wr && hit(paddr, rsf_pkg::A_NVCMD);
  wire nv_store = wr_nv && pwdata[rsf_pkg::NV_STORE];
  wire nv_rest = wr_nv && pwdata[rsf_pkg::NV_RESTORE];
  wire [1:0] nv_lvl = pwdata[rsf_pkg::NV_LVL +: 2];
  wire rest_fact = nv_rest && (nv_lvl == rsf_pkg::LVL_FACTORY);
  wire rest_user = nv_rest && (nv_lvl == rsf_pkg::LVL_USER) && nvm_valid;
  wire rest_bad = nv_rest && !rest_fact && !rest_user;
  wire load_en = (init_pend && nvm_valid) || rest_fact || rest_user;
  wire [63:0] load_val = rest_fact ? rsf_pkg::DEF_CFG : nvm_rd_data;

  // Settings; reset leaves the factory values, a load replaces them all
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {ut_lim, ot_lim, shut_resp, ext_sel, grp_id, follow, bcast,
       next_id, prev_id, own_id, phase} <= rsf_pkg::DEF_CFG;
    end else if (load_en) begin
      {ut_lim, ot_lim, shut_resp, ext_sel, grp_id, follow, bcast,
       next_id, prev_id, own_id, phase} <= load_val;
    end else if (wr) begin
      if (hit(paddr, rsf_pkg::A_PHASE)) phase <= pwdata[3:0];
      if (hit(paddr, rsf_pkg::A_CHAIN)) begin
        own_id <= pwdata[5:0];
        prev_id <= pwdata[rsf_pkg::CH_PREV +: 6];
        next_id <= pwdata[rsf_pkg::CH_NEXT +: 6];
      end
      if (hit(paddr, rsf_pkg::A_FGROUP)) begin
        bcast <= pwdata[rsf_pkg::FG_BC];
        follow <= pwdata[rsf_pkg::FG_FOL];
        grp_id <= pwdata[rsf_pkg::FG_GRP +: 6];
      end
      if (hit(paddr, rsf_pkg::A_USER)) begin
        ext_sel <= pwdata[rsf_pkg::U_EXT];
        shut_resp <= pwdata[rsf_pkg::U_SHUT];
      end
      if (hit(paddr, rsf_pkg::A_OTLIM)) ot_lim <= pwdata[15:0];
      if (hit(paddr, rsf_pkg::A_UTLIM)) ut_lim <= pwdata[15:0];
    end
  end

  // Stored settings are looked at once, right after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) init_pend <= 1'b1;
    else init_pend <= 1'b0;
  end

  // Store request copies the live settings out as one word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nvm_wr <= 1'b0;
      nvm_wr_data <= 64'h0;
    end else begin
      nvm_wr <= nv_store;
      if (nv_store) nvm_wr_data <= cfg;
    end
  end

  // ****************************************
  // Phase offset against the sync clock
  // ****************************************
  logic [15:0] pcnt, per_len;
  logic per_ok;
  wire sync_rise = sync_s && !sync_d;
  wire [19:0] prod = per_len * phase;
  wire [15:0] ph_delay = prod[19:4]; // Period times phase over sixteen

  // Period is measured every sync cycle, so a frequency change settles in one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_d <= 1'b0;
      pcnt <= 16'h0;
      per_len <= 16'h0;
      per_ok <= 1'b0;
      cycle_start <= 1'b0;
    end else begin
      sync_d <= sync_s;
      pcnt <= sync_rise ? 16'h0 : pcnt + 16'h1;
      if (sync_rise) per_len <= pcnt;
      // The count up to the first rise starts at reset, so it is no period
      if (sync_rise) per_ok <= (per_len != 16'h0);
      cycle_start <= per_ok && !sync_rise && (pcnt == ph_delay);
    end
  end

  // ****************************************
  // Inter-module bus receiver
  // ****************************************
  logic rx_busy, rx_vld;
  logic [15:0] rx_cnt;
  logic [3:0] rx_n;
  logic [7:0] rx_sh;
  wire [1:0] rx_typ = rx_sh[7:6];
  wire [5:0] rx_id = rx_sh[5:0];
  wire rx_up_prev = rx_vld && rx_typ == rsf_pkg::MSG_UP && rx_id == prev_id;
  wire rx_dn_next = rx_vld && rx_typ == rsf_pkg::MSG_DOWN && rx_id == next_id;
  wire rx_grp_flt = rx_vld && rx_typ == rsf_pkg::MSG_FAULT && rx_id == grp_id && follow;

  // Start bit is checked half a bit in; data bits follow lsb first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      imb_d <= 1'b0; // Matches the synchroniser's reset output, so no false start
      rx_busy <= 1'b0;
      rx_vld <= 1'b0;
      rx_cnt <= 16'h0;
      rx_n <= 4'h0;
      rx_sh <= 8'h00;
    end else begin
      imb_d <= imb_s;
      rx_vld <= 1'b0;
      if (!rx_busy) begin
        rx_busy <= imb_d && !imb_s;
        rx_cnt <= 16'(rsf_pkg::BIT_CYC / 2);
        rx_n <= 4'h0;
      end else if (rx_cnt != 16'h0) begin
        rx_cnt <= rx_cnt - 16'h1;
      end else begin
        rx_cnt <= 16'(rsf_pkg::BIT_CYC - 1);
        rx_n <= rx_n + 4'h1;
        if (rx_n != 4'h0) rx_sh <= {imb_s, rx_sh[7:1]};
        if ((rx_n == 4'h0 && imb_s) || rx_n == 4'h8) rx_busy <= 1'b0;
        rx_vld <= (rx_n == 4'h8);
      end
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  rsf_pkg::rsf_state_t st, next_st;
  logic [15:0] retry_cnt;
  wire [15:0] temp_sel = ext_sel ? mon_temp_ext : mon_temp_int;
  wire ot_flt = $signed(temp_sel) > $signed(ot_lim);
  wire ut_flt = $signed(temp_sel) < $signed(ut_lim);
  wire own_flt = nd_fault || ot_flt || ut_flt;
  wire own_shut = own_flt && shut_resp;
  wire live = st == rsf_pkg::S_RAMP || st == rsf_pkg::S_ON || st == rsf_pkg::S_WAIT_NEXT;
  wire go_flt = live && (own_shut || rx_grp_flt);
  wire start_st = (prev_id == rsf_pkg::ID_NONE); // Head of chain needs no go-ahead

  // Next state
  always_comb begin
    next_st = st;
    case (st)
      rsf_pkg::S_OFF: begin
        if (en_s) next_st = start_st ? rsf_pkg::S_RAMP : rsf_pkg::S_WAIT_PREV;
      end
      rsf_pkg::S_WAIT_PREV: begin
        if (!en_s) next_st = rsf_pkg::S_OFF;
        else if (rx_up_prev) next_st = rsf_pkg::S_RAMP;
      end
      rsf_pkg::S_RAMP: begin
        if (go_flt) next_st = rsf_pkg::S_FAULT;
        else if (!en_s) next_st = rsf_pkg::S_WAIT_NEXT;
        else if (pg_s) next_st = rsf_pkg::S_ON;
      end
      rsf_pkg::S_ON: begin
        if (go_flt) next_st = rsf_pkg::S_FAULT;
        else if (!en_s) next_st = rsf_pkg::S_WAIT_NEXT;
      end
      rsf_pkg::S_WAIT_NEXT: begin
        if (go_flt) next_st = rsf_pkg::S_FAULT;
        else if (next_id == rsf_pkg::ID_NONE || rx_dn_next) next_st = rsf_pkg::S_OFF;
      end
      rsf_pkg::S_FAULT: begin
        if (retry_cnt == 16'h0) begin
          if (!en_s) next_st = rsf_pkg::S_OFF;
          else next_st = start_st ? rsf_pkg::S_RAMP : rsf_pkg::S_WAIT_PREV;
        end
      end
      default: next_st = rsf_pkg::S_OFF;
    endcase
  end

  // Messages leaving the sequencer
  wire snd_up = st == rsf_pkg::S_RAMP && next_st == rsf_pkg::S_ON;
  wire snd_dn = st == rsf_pkg::S_WAIT_NEXT && next_st == rsf_pkg::S_OFF;
  wire snd_flt = go_flt && own_shut && bcast;
  wire snd = snd_up || snd_dn || snd_flt;
  wire [7:0] snd_byte = snd_flt ? {rsf_pkg::MSG_FAULT, grp_id} :
                        {(snd_up ? rsf_pkg::MSG_UP : rsf_pkg::MSG_DOWN), own_id};
  wire next_live = next_st == rsf_pkg::S_RAMP || next_st == rsf_pkg::S_ON ||
                   next_st == rsf_pkg::S_WAIT_NEXT;

  // State, rail drive and retry wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= rsf_pkg::S_OFF;
      rail_en <= 1'b0;
      retry_cnt <= 16'h0;
    end else begin
      st <= next_st;
      rail_en <= next_live;
      if (go_flt) retry_cnt <= 16'(rsf_pkg::RETRY_CYC - 1);
      else if (retry_cnt != 16'h0) retry_cnt <= retry_cnt - 16'h1;
    end
  end

  // ****************************************
  // Inter-module bus transmitter
  // ****************************************
  // No arbitration: a message sent over another is lost on both ends
  logic tx_pend, tx_busy;
  logic [7:0] tx_byte;
  logic [9:0] tx_sh;
  logic [15:0] tx_cnt;
  logic [3:0] tx_n;
  wire tx_go = tx_pend && !tx_busy;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_pend <= 1'b0;
      tx_byte <= 8'h00;
      tx_busy <= 1'b0;
      tx_sh <= 10'h3FF;
      tx_cnt <= 16'h0;
      tx_n <= 4'h0;
      imb_out <= 1'b1;
      imb_oe_n <= 1'b1;
    end else begin
      tx_pend <= snd || (tx_pend && !tx_go);
      if (snd) tx_byte <= snd_byte;
      if (tx_go) begin
        tx_busy <= 1'b1;
        tx_sh <= {1'b1, tx_byte, 1'b0};
        tx_cnt <= 16'(rsf_pkg::BIT_CYC - 1);
        tx_n <= 4'h0;
      end else if (tx_busy && tx_cnt != 16'h0) begin
        tx_cnt <= tx_cnt - 16'h1;
      end else if (tx_busy) begin
        tx_cnt <= 16'(rsf_pkg::BIT_CYC - 1);
        tx_sh <= {1'b1, tx_sh[9:1]};
        tx_n <= tx_n + 4'h1;
        if (tx_n == 4'h9) tx_busy <= 1'b0;
      end
      imb_out <= 1'b0;
      imb_oe_n <= !(tx_busy && !tx_sh[0]);
    end
  end

  // ****************************************
  // Fault snapshot and interrupts
  // ****************************************
  logic [31:0] snap [4];
  wire [IRQ_W_L-1:0] ev;
  assign ev[rsf_pkg::I_FAULT] = own_flt && live;
  assign ev[rsf_pkg::I_GRP] = rx_grp_flt;
  assign ev[rsf_pkg::I_SEQ] = snd_up || snd_dn;
  assign ev[rsf_pkg::I_STORE] = nv_store;
  assign ev[rsf_pkg::I_REFUSE] = rest_bad;
  wire wr_iclr = wr && hit(paddr, rsf_pkg::A_ICLR);
  wire [IRQ_W_L-1:0] clr = wr_iclr ? pwdata[IRQ_W_L-1:0] : '0;

  // Snapshot is taken when the rail is shut by any fault
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 4; i++) snap[i] <= 32'h0;
    end else if (go_flt) begin
      snap[0] <= {mon_vout, mon_vin};
      snap[1] <= {temp_sel, mon_iout};
      snap[2] <= {mon_aux, mon_duty};
      snap[3] <= {28'h0, rx_grp_flt, ut_flt, ot_flt, nd_fault};
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istat <= '0;
      ien <= '0;
      irq <= 1'b0;
    end else begin
      istat <= (istat & ~clr) | ev;
      if (wr && hit(paddr, rsf_pkg::A_IEN)) ien <= pwdata[IRQ_W_L-1:0];
      irq <= |(istat & ien);
    end
  end

  // ****************************************
  // APB read path; one wait state on every access
  // ****************************************
  logic [15:0] mon [8];
  assign mon[0] = mon_vin;
  assign mon[1] = mon_vout;
  assign mon[2] = mon_iout;
  assign mon[3] = mon_temp_int;
  assign mon[4] = mon_temp_ext;
  assign mon[5] = mon_duty;
  assign mon[6] = mon_freq;
  assign mon[7] = mon_aux;
  wire is_mon = paddr[7:5] == rsf_pkg::A_MON_HI;
  wire is_snap = paddr[7:4] == rsf_pkg::A_SNAP_HI;
  wire [31:0] st_word = {22'h0, st, rail_en, pg_s, en_s, !init_pend};
  wire [31:0] rd_val =
    is_mon ? {16'h0, mon[paddr[4:2]]} :
    is_snap ? snap[paddr[3:2]] :
    hit(paddr, rsf_pkg::A_PHASE) ? {28'h0, phase} :
    hit(paddr, rsf_pkg::A_CHAIN) ? {10'h0, next_id, 2'h0, prev_id, 2'h0, own_id} :
    hit(paddr, rsf_pkg::A_FGROUP) ? {18'h0, grp_id, 6'h0, follow, bcast} :
    hit(paddr, rsf_pkg::A_USER) ? {30'h0, shut_resp, ext_sel} :
    hit(paddr, rsf_pkg::A_OTLIM) ? {16'h0, ot_lim} :
    hit(paddr, rsf_pkg::A_UTLIM) ? {16'h0, ut_lim} :
    hit(paddr, rsf_pkg::A_STATE) ? st_word :
    hit(paddr, rsf_pkg::A_ISTAT) ? {27'h0, istat} :
    hit(paddr, rsf_pkg::A_IEN) ? {27'h0, ien} : 32'h0;
  wire rd_ok = is_mon || is_snap || (paddr <= rsf_pkg::A_ICLR && paddr[1:0] == 2'h0);

  // Answer registered one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= acc_wait;
      if (acc_wait) prdata <= pwrite ? 32'h0 : rd_val;
      if (acc_wait) pslverr <= !rd_ok;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_ramp_done;
    st == rsf_pkg::S_RAMP && !go_flt && en_s && pg_s;
  endsequence

  a_irq_level: assert property ((|(istat & ien)) |=> irq)
    else $error("irq low with enabled status");
  a_apb_wait: assert property (acc_wait |=> pready ##1 !pready)
    else $error("apb answer timing wrong");
  a_fault_off: assert property (live && own_shut |=> !rail_en ##1 !rail_en)
    else $error("rail not off after own fault");
  a_follow_off: assert property (live && rx_grp_flt |=> !rail_en)
    else $error("rail not off after group fault");
  a_bad_restore: assert property (rest_bad && !init_pend |=> $stable(cfg))
    else $error("protected restore changed settings");
  a_store_word: assert property (nv_store |=> nvm_wr && nvm_wr_data == $past(cfg))
    else $error("store did not write settings");
  a_wait_prev: assert property (st == rsf_pkg::S_WAIT_PREV && !rx_up_prev |=> !rail_en)
    else $error("ramp before predecessor");
  a_chain_hold: assert property (wr && hit(paddr, rsf_pkg::A_CHAIN) && !load_en
      |=> prev_id == $past(pwdata[13:8]) && next_id == $past(pwdata[21:16]))
    else $error("chain links not held");
  a_up_msg: assert property (s_ramp_done |=> tx_pend ##0 tx_byte[7:6] == rsf_pkg::MSG_UP)
    else $error("no up message after ramp");
  a_snap_vin: assert property (go_flt |=> snap[0][15:0] == $past(mon_vin))
    else $error("snapshot not taken");

endmodule // rsf_top

`default_nettype wire

//--- bench/rsf_peer.sv
`timescale 1ns/1ps
`default_nettype none

// Peer module on the shared open-drain wire
module rsf_peer (
  // Clock and wire
  input wire logic pclk,
  input wire logic wire_lvl,
  output logic pull
);
  localparam int BT = rsf_pkg::BIT_CYC;

  // Released wire is left to the pull-up
  initial pull = 1'b0;

  // Frame out: start low, eight bits lsb first, stop high
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      pull <= ~f[i];
      repeat (BT) @(posedge pclk);
    end
  endtask

  // Frame in: sample each bit at its middle; gives up when no start comes
  task automatic recv(output logic [7:0] b, output bit ok);
    ok = 1'b0;
    b = 8'h00;
    for (int n = 0; n < 20000 && !ok; n++) begin
      @(posedge pclk);
      ok = !wire_lvl;
    end
    repeat (BT + BT / 2) @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      b[i] = wire_lvl;
      repeat (BT) @(posedge pclk);
    end
  endtask
endmodule // rsf_peer

`default_nettype wire

//--- bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  // ****
  // Signals
  // ****
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr, rx;
  logic [31:0] pwdata, prdata, rv, seed;
  logic grp_enable, pg_in, nd_fault, imb_out, imb_oe_n, rail_en, cycle_start;
  logic nvm_valid, nvm_wr, irq, pull, wire_lvl, sync_clk;
  logic [63:0] nvm_rd_data, nvm_wr_data;
  logic [63:0] nvq = 64'h0;
  logic [15:0] mon [8];
  logic [8:0] scnt = 9'h000;
  logic [8:0] t1, t2;
  int failures, cmp_count;
  bit ok;

  // Wired-AND bus, pull-up when nobody drives
  assign wire_lvl = (imb_oe_n | imb_out) & ~pull;
  // One common switching clock for the whole group
  assign sync_clk = scnt[8];

  rsf_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .grp_enable(grp_enable), .sync_clk(sync_clk), .imb_in(wire_lvl),
    .imb_out(imb_out), .imb_oe_n(imb_oe_n), .pg_in(pg_in), .nd_fault(nd_fault),
    .rail_en(rail_en), .cycle_start(cycle_start), .mon_vin(mon[0]), .mon_vout(mon[1]),
    .mon_iout(mon[2]), .mon_temp_int(mon[3]), .mon_temp_ext(mon[4]), .mon_duty(mon[5]),
    .mon_freq(mon[6]), .mon_aux(mon[7]), .nvm_valid(nvm_valid),
    .nvm_rd_data(nvm_rd_data), .nvm_wr(nvm_wr), .nvm_wr_data(nvm_wr_data), .irq(irq));
  rsf_peer peer (.pclk(pclk), .wire_lvl(wire_lvl), .pull(pull));

  // Clock, sync counter and capture of the one-cycle store pulse
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) scnt <= scnt + 9'h001;
  always @(posedge pclk) if (nvm_wr === 1'b1) nvq <= nvm_wr_data;

  // ****
  // Helpers
  // ****
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  task automatic summarize;
    $display("checks %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask

  // APB transfer; the request stands until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rv = prdata;
    er = pslverr;
    if (n >= 50) begin
      failures++;
      summarize();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rv, e);
  endtask

  task automatic wrail(input logic v);
    for (int n = 0; n < 2000 && rail_en !== v; n++) @(posedge pclk);
    chk(rail_en, v);
  endtask

  task automatic rxchk(input logic [7:0] e);
    peer.recv(rx, ok);
    if (!ok) begin
      failures++;
      summarize();
    end else
      chk(rx, e);
  endtask

  // Predecessor reports up, then power good; device answers with its own up frame
  task automatic up_seq;
    peer.send({rsf_pkg::MSG_UP, 6'd5});
    wrail(1'b1);
    pg_in <= 1'b1;
    rxchk({rsf_pkg::MSG_UP, 6'd3});
  endtask

  task automatic phase_at(input logic [31:0] p, output logic [8:0] t);
    wr(rsf_pkg::A_PHASE, p);
    repeat (1100) @(posedge pclk);
    for (int n = 0; n < 600 && cycle_start !== 1'b1; n++) @(posedge pclk);
    t = scnt;
    chk(cycle_start, 1'b1);
  endtask

  // ****
  // Main sequence
  // ****
  initial begin
    {psel, penable, pwrite, paddr, pwdata, grp_enable, pg_in, nd_fault} = '0;
    mon = '{default: 16'h0000};
    nvm_valid = 1'b1;
    nvm_rd_data = rsf_pkg::DEF_CFG | 64'h5;
    seed = 32'd15153;
    presetn = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    rd(rsf_pkg::A_PHASE, 32'h5);
    rd(rsf_pkg::A_OTLIM, 32'h007D);
    rd(rsf_pkg::A_USER, 32'h2);
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      wr(rsf_pkg::A_CHAIN, seed);
      rd(rsf_pkg::A_CHAIN, seed & 32'h003F3F3F);
    end
    apb(1'b0, 8'h30, 32'h0);
    chk({er, rv}, {1'b1, 32'h0});
    $display("test registers done");
    // Random monitor values; temperatures kept inside the limits
    for (int k = 0; k < 8; k++) begin
      seed = xs(seed);
      mon[k] <= (k == 3 || k == 4) ? {10'h0, seed[5:0]} : seed[15:0];
    end
    @(posedge pclk);
    for (int k = 0; k < 8; k++) rd(8'(8'h40 + 4 * k), {16'h0, mon[k]});
    wr(rsf_pkg::A_IEN, 32'h18);
    wr(rsf_pkg::A_NVCMD, 32'hA);
    rd(rsf_pkg::A_ISTAT, 32'h10);
    chk(irq, 1'b1);
    wr(rsf_pkg::A_IEN, 32'h08);
    rd(rsf_pkg::A_ISTAT, 32'h10);
    chk(irq, 1'b0);
    phase_at(32'h4, t1);
    phase_at(32'hC, t2);
    chk(9'(t2 - t1), 9'd256);
    $display("test monitors phase done");
    wr(rsf_pkg::A_CHAIN, 32'h0503);
    wr(rsf_pkg::A_FGROUP, 32'h0903);
    wr(rsf_pkg::A_USER, 32'h3);
    wr(rsf_pkg::A_ICLR, 32'h1F);
    wr(rsf_pkg::A_IEN, 32'h03);
    grp_enable <= 1'b1;
    repeat (8) @(posedge pclk);
    rd(rsf_pkg::A_STATE, 32'h23);
    up_seq();
    rd(rsf_pkg::A_STATE, 32'h8F);
    // Hot external diode while the internal sensor stays cool
    mon[4] <= 16'h0100;
    rxchk({rsf_pkg::MSG_FAULT, 6'd9});
    chk(rail_en, 1'b0);
    chk(irq, 1'b1);
    mon[0] <= ~mon[0];
    rd(8'h60, {mon[1], mon[0]});
    rd(8'h6C, 32'h2);
    mon[4] <= 16'h0000;
    pg_in <= 1'b0;
    wr(rsf_pkg::A_ICLR, 32'h1F);
    repeat (rsf_pkg::RETRY_CYC + 200) @(posedge pclk);
    rd(rsf_pkg::A_STATE, 32'h23);
    chk(irq, 1'b0);
    up_seq();
    peer.send({rsf_pkg::MSG_FAULT, 6'd9});
    wrail(1'b0);
    rd(rsf_pkg::A_ISTAT, 32'h06);
    $display("test faults done");
    pg_in <= 1'b0;
    repeat (rsf_pkg::RETRY_CYC + 200) @(posedge pclk);
    up_seq();
    grp_enable <= 1'b0;
    rxchk({rsf_pkg::MSG_DOWN, 6'd3});
    wrail(1'b0);
    rd(rsf_pkg::A_STATE, 32'h15);
    wr(rsf_pkg::A_NVCMD, 32'h1);
    @(posedge pclk);
    chk(nvq, {16'hFFD3, 16'h007D, 2'b11, 6'd9, 2'b11, 6'd0, 6'd5, 6'd3, 4'hC});
    // User level restore brings back the fixed word on nvm_rd_data, factory level the defaults
    wr(rsf_pkg::A_NVCMD, 32'h2);
    rd(rsf_pkg::A_PHASE, 32'h5);
    wr(rsf_pkg::A_NVCMD, 32'h6);
    rd(rsf_pkg::A_CHAIN, 32'h0);
    $display("test order store done");
    summarize();
  end

  // Watchdog against a hang
  initial begin
    repeat (90000) @(posedge pclk);
    failures++;
    summarize();
  end
endmodule // tb_top

`default_nettype wire
